// file: design/ufb_pkg.sv
// Purpose: shared constants and types for the fifo control and baud generator block
// Assumes: 8-bit register port, channel offsets 0..7
// Notes:   divisor reset value is arbitrary; software loads it at init
package ufb_pkg;

    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;
    localparam int          DIV_W           = 16;

    // channel offsets
    localparam logic [2:0]  OFS_DIV_LOW     = 3'h0;
    localparam logic [2:0]  OFS_DIV_HIGH    = 3'h1;
    localparam logic [2:0]  OFS_FIFO_CTRL   = 3'h2;

    // fifo_control field positions
    localparam int          FC_ENABLE_BIT   = 0;
    localparam int          FC_RX_CLR_BIT   = 1;
    localparam int          FC_TX_CLR_BIT   = 2;
    localparam int          FC_DMA_BIT      = 3;
    localparam int          FC_TRIG_LSB     = 6;

    // reset values
    localparam logic [7:0]  DIV_LOW_RESET   = 8'h01;
    localparam logic [7:0]  DIV_HIGH_RESET  = 8'h00;
    localparam logic [7:0]  RDATA_NONE      = 8'h00;

    // receive trigger depths in bytes
    localparam logic [3:0]  TRIG_BYTES_0    = 4'h1;
    localparam logic [3:0]  TRIG_BYTES_1    = 4'h4;
    localparam logic [3:0]  TRIG_BYTES_2    = 4'h8;
    localparam logic [3:0]  TRIG_BYTES_3    = 4'he;

    // baud output is this many times the bit rate
    localparam int          OVERSAMPLE      = 16;

    typedef enum logic [1:0] {
        UFB_TRIG_1,
        UFB_TRIG_4,
        UFB_TRIG_8,
        UFB_TRIG_14
    } ufb_trig_e;

    // stored fifo_control state (clear bits are never stored)
    typedef struct packed {
        ufb_trig_e  trig;
        logic       dma_mode;
        logic       enable;
    } ufb_fifo_ctrl_s;

    // one-cycle clear commands to the fifos
    typedef struct packed {
        logic       tx_clear;
        logic       rx_clear;
    } ufb_fifo_clr_s;

    localparam ufb_fifo_ctrl_s FIFO_CTRL_RESET = '{trig: UFB_TRIG_1, dma_mode: 1'b0,
                                                   enable: 1'b0};

endpackage : ufb_pkg

// file: design/ufb_fifo_baud.sv
// Purpose: fifo control register, divisor latches and 16x baud generator for one channel
// Assumes: register port and divisor_access_select come from logic on mclk_i
// Notes:   offsets 0/1 with select low and reads of offset 2 belong to neighbouring logic;
//          this block answers them with zero except the fifo-mode id bits at offset 2
// Notes on behaviour
// - bits 7:6 pick trigger 1/4/8/14 bytes
// - bit 3 stored, changes nothing
// - bit 2 pulses transmit fifo clear, self-clears
// - bit 1 pulses receive fifo clear only
// - bit 0 high enables both fifos
// - bit 0 low when enabled disables and empties both
// - writes with bit 0 low ignore others
// - leaving fifo mode clears every field
// - offset 2 write-only, never read back
// - divisor latches at 0/1 when select high
// - divide clock by divisor 1..65536
// - tick is sixteen times bit rate
// - select high maps divisor latches at 0/1
// - fifo enabled reports id bits 7:6 set
module ufb_fifo_baud
    import ufb_pkg::*;
(
    // clock, reset, enable
    input  wire logic                       mclk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       clk_en_i,
    // register port
    input  wire logic [ufb_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [ufb_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [ufb_pkg::DATA_W-1:0] rdata_o,
    // from line format control
    input  wire logic                       divisor_access_select_i,
    // fifo control to the fifos and interrupt logic
    output logic                            fifo_enable_o,
    output ufb_pkg::ufb_fifo_clr_s          fifo_clr_o,
    output logic      [3:0]                 rx_trigger_bytes_o,
    output logic                            dma_mode_o,
    output logic      [1:0]                 fifo_mode_id_o,
    // baud generator
    output logic      [ufb_pkg::DIV_W-1:0]  divisor_o,
    output logic                            baud_tick_o
);
    import ufb_pkg::*;

    ufb_fifo_ctrl_s         fc_q;
    ufb_fifo_ctrl_s         fc_d;
    ufb_fifo_clr_s          clr_q;
    ufb_fifo_clr_s          clr_d;
    logic [7:0]             div_low_q;
    logic [7:0]             div_high_q;
    logic [DIV_W-1:0]       cnt_q;
    logic [DIV_W-1:0]       cnt_d;
    logic                   tick_q;
    logic [DATA_W-1:0]      rdata_q;
    logic [DATA_W-1:0]      rdata_d;

    // address decode
    wire logic              hit_div_low  = divisor_access_select_i
                                           && (addr_i == OFS_DIV_LOW);
    wire logic              hit_div_high = divisor_access_select_i
                                           && (addr_i == OFS_DIV_HIGH);
    wire logic              hit_fc       = (addr_i == OFS_FIFO_CTRL);
    wire logic              wr_fc        = wr_i && hit_fc;
    wire logic              wr_div_low   = wr_i && hit_div_low;
    wire logic              wr_div_high  = wr_i && hit_div_high;
    wire logic              wr_en_bit    = wdata_i[FC_ENABLE_BIT];
    wire logic [DIV_W-1:0]  divisor      = {div_high_q, div_low_q};
    // a latch write restarts the count from the value being written, not the old one
    wire logic [7:0]        div_low_d    = wr_div_low ? wdata_i : div_low_q;
    wire logic [7:0]        div_high_d   = wr_div_high ? wdata_i : div_high_q;
    wire logic [DIV_W-1:0]  div_next     = {div_high_d, div_low_d};
    // all-zero divisor wraps to ffff, giving 65536 cycles per tick
    wire logic [DIV_W-1:0]  reload       = div_next - 16'h0001;
    wire logic              cnt_zero     = (cnt_q == 16'h0000);

    // fifo_control next value
    always_comb
    begin
        fc_d  = fc_q;
        clr_d = '0;
        if (wr_fc)
        begin
            if (wr_en_bit)
            begin
                fc_d.enable   = 1'b1;
                fc_d.dma_mode = wdata_i[FC_DMA_BIT];
                fc_d.trig     = ufb_trig_e'(wdata_i[FC_TRIG_LSB +: 2]);
                clr_d.tx_clear = wdata_i[FC_TX_CLR_BIT];
                clr_d.rx_clear = wdata_i[FC_RX_CLR_BIT];
            end
            else
            begin
                // other bits ignored; whole register returns to non-fifo state
                fc_d = FIFO_CTRL_RESET;
                clr_d.tx_clear = fc_q.enable;
                clr_d.rx_clear = fc_q.enable;
            end
        end
    end

    // read path: offset 2 never returns fifo_control, only the mode id bits
    always_comb
    begin
        rdata_d = RDATA_NONE;
        if (hit_div_low)
        begin
            rdata_d = div_low_q;
        end
        else if (hit_div_high)
        begin
            rdata_d = div_high_q;
        end
        else if (hit_fc)
        begin
            rdata_d = {fifo_mode_id_o, 6'h00};
        end
    end

    // baud counter counts down from divisor-1, tick on zero
    always_comb
    begin
        cnt_d = cnt_q - 16'h0001;
        if (cnt_zero || wr_div_low || wr_div_high)
        begin
            cnt_d = reload;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            fc_q       <= FIFO_CTRL_RESET;
            clr_q      <= '0;
            div_low_q  <= DIV_LOW_RESET;
            div_high_q <= DIV_HIGH_RESET;
            rdata_q    <= RDATA_NONE;
        end
        else if (clk_en_i)
        begin
            fc_q    <= fc_d;
            clr_q   <= clr_d;
            rdata_q <= rd_i ? rdata_d : RDATA_NONE;
            if (wr_div_low)
            begin
                div_low_q <= wdata_i;
            end
            if (wr_div_high)
            begin
                div_high_q <= wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            cnt_q  <= cnt_d;
            tick_q <= cnt_zero && !(wr_div_low || wr_div_high);
        end
        else
        begin
            tick_q <= 1'b0;
        end
    end

    // trigger depth decode
    always_comb
    begin
        case (fc_q.trig)
            UFB_TRIG_1:  rx_trigger_bytes_o = TRIG_BYTES_0;
            UFB_TRIG_4:  rx_trigger_bytes_o = TRIG_BYTES_1;
            UFB_TRIG_8:  rx_trigger_bytes_o = TRIG_BYTES_2;
            default:     rx_trigger_bytes_o = TRIG_BYTES_3;
        endcase
    end

    assign fifo_enable_o  = fc_q.enable;
    assign fifo_clr_o     = clr_q;
    assign dma_mode_o     = fc_q.dma_mode;
    assign fifo_mode_id_o = {fc_q.enable, fc_q.enable};
    assign divisor_o      = divisor;
    assign baud_tick_o    = tick_q;
    assign rdata_o        = rdata_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_fc_write_on;
        clk_en_i && wr_fc && wr_en_bit;
    endsequence

    sequence s_fc_write_off;
        clk_en_i && wr_fc && !wr_en_bit;
    endsequence

    sequence s_div_write;
        clk_en_i && (wr_div_low || wr_div_high);
    endsequence

    a_trigger_decode: assert property (
        s_fc_write_on |=> rx_trigger_bytes_o ==
            (($past(wdata_i[7:6]) == 2'b00) ? 4'h1 : ($past(wdata_i[7:6]) == 2'b01) ? 4'h4 :
             ($past(wdata_i[7:6]) == 2'b10) ? 4'h8 : 4'he))
        else $error("trigger depth does not follow written code");

    a_tx_clear_pulse: assert property (
        s_fc_write_on ##0 wdata_i[2] |=> fifo_clr_o.tx_clear
            ##1 (!fifo_clr_o.tx_clear || $past(wr_fc) || !$past(clk_en_i)))
        else $error("transmit clear not a single pulse");

    a_rx_clear_only: assert property (
        s_fc_write_on ##0 wdata_i[1] ##0 !wdata_i[2]
            |=> fifo_clr_o.rx_clear && !fifo_clr_o.tx_clear)
        else $error("receive clear wrong");

    a_enable_set: assert property (
        s_fc_write_on |=> fifo_enable_o && fifo_mode_id_o == 2'b11)
        else $error("fifo enable not set");

    a_disable_clear: assert property (
        s_fc_write_off ##0 fifo_enable_o |=> !fifo_enable_o && fifo_clr_o.rx_clear
            && fifo_clr_o.tx_clear && rx_trigger_bytes_o == 4'h1 && !dma_mode_o)
        else $error("disable did not clear fifos and fields");

    a_fc_no_readback: assert property (
        clk_en_i && rd_i && hit_fc |=> rdata_o[5:0] == 6'h00
            && rdata_o[7:6] == {2{$past(fifo_enable_o)}})
        else $error("fifo_control leaked on read");

    a_div_readback: assert property (
        clk_en_i && wr_div_high ##1 clk_en_i && rd_i && hit_div_high && !wr_i
            |=> rdata_o == $past(wdata_i, 2))
        else $error("divisor high latch read back wrong");

    a_div_hidden: assert property (
        clk_en_i && rd_i && !divisor_access_select_i && addr_i != OFS_FIFO_CTRL
            |=> rdata_o == 8'h00)
        else $error("divisor visible with select low");

    a_tick_period_one: assert property (
        clk_en_i && baud_tick_o && divisor == 16'h0001 && !wr_i
            ##1 clk_en_i && !wr_i |=> baud_tick_o)
        else $error("divisor one does not tick every cycle");

    a_tick_period_n: assert property (
        clk_en_i && cnt_zero && !wr_div_low && !wr_div_high && divisor == 16'h0003
            ##1 (clk_en_i && !wr_i) [*3] |-> cnt_zero)
        else $error("divisor three period wrong");

    a_zero_divisor: assert property (
        clk_en_i && cnt_zero && !wr_div_low && !wr_div_high && divisor == 16'h0000
            |=> cnt_q == 16'hffff)
        else $error("zero divisor does not reload maximum");

    a_write_no_tick: assert property (
        s_div_write |=> !baud_tick_o)
        else $error("tick during divisor write");

    a_restart_three: assert property (
        s_div_write ##1 (clk_en_i && !wr_i && divisor == 16'h0003) [*3] |=> baud_tick_o)
        else $error("first tick after divisor write late or early");

    a_div_low_write: assert property (
        clk_en_i && wr_div_low |=> divisor_o[7:0] == $past(wdata_i))
        else $error("divisor low latch not written");

    a_div_ignored: assert property (
        clk_en_i && wr_i && !divisor_access_select_i |=> $stable(divisor_o))
        else $error("divisor written with select low");

    a_clear_idle: assert property (
        clk_en_i && !wr_fc |=> fifo_clr_o == 2'b00)
        else $error("fifo clear without a write");

    a_dma_follows: assert property (
        s_fc_write_on |=> dma_mode_o == $past(wdata_i[FC_DMA_BIT]))
        else $error("stored bit 3 wrong");

    a_id_bits_track: assert property (
        clk_en_i && wr_fc |=> fifo_mode_id_o == {2{$past(wr_en_bit)}})
        else $error("fifo mode id bits wrong");

    a_rdata_idle: assert property (
        clk_en_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data without a read");

    a_clken_freeze: assert property (
        !clk_en_i |=> $stable(fifo_enable_o) && $stable(fifo_clr_o) && $stable(divisor_o)
            && $stable(rx_trigger_bytes_o) && !baud_tick_o)
        else $error("state moved with clock enable low");

endmodule : ufb_fifo_baud

// file: verification/ufb_tick_meter.sv
// Purpose: far-side meter of the 16x baud tick
// Assumes: tick is a one-cycle pulse on mclk_i
// Notes:   period_o holds the cycle count between the last two ticks
module ufb_tick_meter
(
    // clock, reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // tick from the generator
    input  wire logic        tick_i,
    output logic      [16:0] period_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] cnt_q;
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q    <= 17'h00001;
            period_o <= 17'h00000;
        end
        else if (tick_i)
        begin
            period_o <= cnt_q;
            cnt_q    <= 17'h00001;
        end
        else
        begin
            cnt_q <= cnt_q + 17'h00001;
        end
    end
endmodule : ufb_tick_meter

// file: verification/testbench.sv
// Purpose: self-checking bench for fifo control and baud generator
// Assumes: register port answers reads one cycle after the strobe
// Notes:   random fifo_control bits and divisor drawn from a fixed seed
module testbench;
    import ufb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [2:0]  addr_i = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        sel_i = 1'b1;
    logic        clk_en_i = 1'b1;
    logic [7:0]  rdata_o;
    logic        fifo_enable_o;
    ufb_fifo_clr_s fifo_clr_o;
    logic [3:0]  rx_trigger_bytes_o;
    logic        dma_mode_o;
    logic [1:0]  fifo_mode_id_o;
    logic [15:0] divisor_o;
    logic        baud_tick_o;
    logic [16:0] period_o;
    int          num_errors = 0;
    int          total_checks = 0;
    int          seed;
    logic [7:0]  w;
    logic [15:0] divs [7];

    ufb_fifo_baud ufb_fifo_baud_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .divisor_access_select_i(sel_i), .fifo_enable_o(fifo_enable_o),
        .fifo_clr_o(fifo_clr_o), .rx_trigger_bytes_o(rx_trigger_bytes_o),
        .dma_mode_o(dma_mode_o), .fifo_mode_id_o(fifo_mode_id_o),
        .divisor_o(divisor_o), .baud_tick_o(baud_tick_o));
    ufb_tick_meter ufb_tick_meter_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .tick_i(baud_tick_o), .period_o(period_o));

    always #5 mclk_i = ~mclk_i;

    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(17'(rdata_o), 17'(exp));
    endtask : rd

    // cycles from the write edge to the first tick
    task automatic first_tick(input logic [16:0] d);
        logic [16:0] n;
        n = 17'h0;
        while (baud_tick_o !== 1'b1)
        begin
            @(posedge mclk_i);
            #1;
            n++;
            if (n > 17'h10010)
            begin
                num_errors++;
                stop_test();
            end
        end
        chk(n, d);
    endtask : first_tick

    function automatic logic [3:0] trig_of(input logic [1:0] c);
        return (c == 2'h0) ? 4'h1 : (c == 2'h1) ? 4'h4 : (c == 2'h2) ? 4'h8 : 4'he;
    endfunction : trig_of

    initial
    begin
        seed = 32'h6b4147b8;
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        #1;
        chk(17'(divisor_o), 17'h1);
        chk(17'({fifo_enable_o, rx_trigger_bytes_o}), 17'h1);
        for (int c = 0; c < 4; c++)
        begin
            w = 8'($random(seed));
            w = {2'(c), w[5:1], 1'b1};
            wr(OFS_FIFO_CTRL, w);
            chk(17'(rx_trigger_bytes_o), 17'(trig_of(w[7:6])));
            chk(17'({fifo_enable_o, fifo_mode_id_o}), 17'h7);
            chk(17'(dma_mode_o), 17'(w[3]));
            chk(17'(fifo_clr_o), 17'({w[2], w[1]}));
            @(posedge mclk_i);
            #1;
            chk(17'(fifo_clr_o), 17'h0);
        end
        wr(OFS_FIFO_CTRL, 8'h03);
        chk(17'(fifo_clr_o), 17'h1);
        wr(OFS_FIFO_CTRL, 8'hc5);
        chk(17'(fifo_clr_o), 17'h2);
        rd(OFS_FIFO_CTRL, 8'hc0);
        wr(OFS_FIFO_CTRL, 8'hca);
        chk(17'({fifo_enable_o, rx_trigger_bytes_o, dma_mode_o}), 17'h2);
        chk(17'({fifo_clr_o, fifo_mode_id_o}), 17'hc);
        rd(OFS_FIFO_CTRL, 8'h00);
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00);
        chk(17'(fifo_enable_o), 17'h0);
        // clock enable low: the write is lost and the tick is held low
        @(posedge mclk_i);
        clk_en_i <= 1'b0;
        wr(OFS_FIFO_CTRL, 8'hc1);
        chk(17'({fifo_enable_o, baud_tick_o, fifo_clr_o}), 17'h0);
        @(posedge mclk_i);
        clk_en_i <= 1'b1;
        divs = '{16'h0001, 16'h0002, 16'h0003, 16'h000c, 16'h0900, 16'h0000, 16'h0000};
        w = 8'($random(seed));
        divs[6] = {8'h00, w | 8'h01};
        foreach (divs[i])
        begin
            wr(OFS_DIV_LOW, divs[i][7:0]);
            wr(OFS_DIV_HIGH, divs[i][15:8]);
            chk(17'(divisor_o), 17'(divs[i]));
            first_tick((divs[i] == 16'h0) ? 17'h10000 : 17'(divs[i]));
            if (divs[i] != 16'h0)
            begin
                repeat (divs[i] + 16'h1) @(posedge mclk_i);
                #1;
                chk(period_o, 17'(divs[i]));
            end
            rd(OFS_DIV_LOW, divs[i][7:0]);
            rd(OFS_DIV_HIGH, divs[i][15:8]);
        end
        // high latch written and read back with no gap between strobes
        @(posedge mclk_i);
        addr_i  <= OFS_DIV_HIGH;
        wdata_i <= 8'h5a;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(17'(rdata_o), 17'h5a);
        @(posedge mclk_i);
        sel_i <= 1'b0;
        wr(OFS_DIV_LOW, 8'h55);
        chk(17'(divisor_o), 17'({8'h5a, divs[6][7:0]}));
        rd(OFS_DIV_LOW, 8'h00);
        stop_test();
    end
endmodule : testbench
